// ### gpm_pkg.sv
// constants, types and state records of the gauge power-mode block
package gpm_pkg;
    // sample and result widths
    localparam int SAMPLE_W  = 12;
    localparam int BIAS_W    = 8;
    localparam int DIFF_W    = 13;
    localparam int AVG_N     = 128;
    localparam int AVG_SHIFT = 7;
    localparam int AVG_CNT_W = 7;
    localparam int SUM_W     = 20;
    localparam int TEMP_W    = 11;
    localparam int TRIM_W    = 8;
    localparam int GAIN_W    = 19;
    localparam int PROD_W    = 32;

    // result limits of the signed 12-bit current result
    localparam logic signed [SAMPLE_W-1:0] RES_MAX = 12'sh7ff;
    localparam logic signed [SAMPLE_W-1:0] RES_MIN = 12'sh800;

    // scale of one result step, internal (uA) and external (nV)
    localparam int INT_LSB_UA  = 625;
    localparam int EXT_LSB_NV  = 15625;
    localparam int EXT_FS_MV   = 64;
    localparam int INT_FS_MA   = 2560;
    localparam int INT_MIN_FS_MA = 1900;

    // timing figures and derived cycle counts at 4 ns
    localparam longint CLK_PERIOD_PS          = 4000;
    localparam longint BUS_LOW_SLEEP_DELAY_MS = 2200;
    localparam longint UNDERVOLTAGE_DELAY_MS  = 100;
    localparam longint REFRESH_PERIOD_US      = 88000;
    localparam longint PS_PER_MS              = 1000000000;
    localparam longint PS_PER_US              = 1000000;
    localparam longint BUS_LOW_SLEEP_CYC =
        (BUS_LOW_SLEEP_DELAY_MS * PS_PER_MS + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam longint UNDERVOLTAGE_CYC =
        (UNDERVOLTAGE_DELAY_MS * PS_PER_MS + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam longint SAMPLE_PERIOD_CYC =
        (REFRESH_PERIOD_US * PS_PER_US) / (AVG_N * CLK_PERIOD_PS);
    localparam int SLEEP_CNT_W = 30;
    localparam int UV_CNT_W    = 25;
    localparam int SMP_CNT_W   = 18;

    // sense-resistor compensation, gain in Q15
    localparam int     GAIN_FRAC     = 15;
    localparam longint GAIN_ONE      = 32768;
    localparam longint TEMPCO_PPM    = 3700;
    localparam longint TEMP_LSB_MC   = 125;
    localparam longint PPM_MC_DIV    = 1000000000;
    localparam longint ALPHA_Q       =
        (TEMPCO_PPM * TEMP_LSB_MC * GAIN_ONE) / PPM_MC_DIV;
    localparam longint REF_TEMP_CODE = 200;
    localparam int     TRIM_SHIFT    = 4;

    typedef enum logic {GPM_ACTIVE, GPM_SLEEP} gpm_mode_e;

    // die temperature and process trim for compensation
    typedef struct packed {
        logic signed [TEMP_W-1:0] die_temp;
        logic signed [TRIM_W-1:0] gain_trim;
    } gpm_comp_s;

    typedef struct packed {
        gpm_mode_e                  mode;
        logic [SLEEP_CNT_W-1:0]     bus_low_cnt;
        logic [UV_CNT_W-1:0]        uv_cnt;
        logic                       bus_prev;
        logic                       uv_meta;
        logic                       uv_sync;
        logic [SMP_CNT_W-1:0]       smp_cnt;
        logic                       smp_req;
        logic signed [SAMPLE_W-1:0] result;
        logic                       update;
        logic                       charging;
        logic                       discharging;
    } gpm_state_s;

    typedef struct packed {
        logic signed [SUM_W-1:0]  sum;
        logic [AVG_CNT_W-1:0]     cnt;
        logic signed [DIFF_W-1:0] avg;
        logic                     done;
    } gpm_avg_s;
endpackage

// ### gpm_avg.sv
// running average of a fixed block of signed current samples
`timescale 1ns/1ps
module gpm_avg #(
    parameter int N_SAMPLES = gpm_pkg::AVG_N
) (
    input  wire logic                               mclk_in,
    input  wire logic                               reset_n_in,
    input  wire logic                               clear_in,
    input  wire logic                               valid_in,
    input  wire logic signed [gpm_pkg::DIFF_W-1:0]  sample_in,
    output logic signed [gpm_pkg::DIFF_W-1:0]       avg_out,
    output logic                                    done_out
);
    import gpm_pkg::*;

    // block size must match the shift that divides the sum
    if (N_SAMPLES != (1 << AVG_SHIFT)) begin : g_bad_n
        $error("gpm_avg: N_SAMPLES must equal the averaging block size");
    end

    gpm_avg_s s;
    gpm_avg_s next_s;
    logic signed [SUM_W-1:0] sum_new;

    // accumulate, divide by shift at block end
    always_comb begin
        next_s  = s;
        sum_new = s.sum + SUM_W'(sample_in);
        next_s.done = 1'b0;
        if (clear_in) begin
            next_s.sum = '0;
            next_s.cnt = '0;
        end else if (valid_in) begin
            if (s.cnt == AVG_CNT_W'(N_SAMPLES - 1)) begin
                next_s.avg  = DIFF_W'(sum_new >>> AVG_SHIFT);
                next_s.sum  = '0;
                next_s.cnt  = '0;
                next_s.done = 1'b1;
            end else begin
                next_s.sum = sum_new;
                next_s.cnt = s.cnt + AVG_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign avg_out  = s.avg;
    assign done_out = s.done;
endmodule

// ### gpm_top.sv
// power-mode controller and current-measurement sequencer
`timescale 1ns/1ps
// Notes on behaviour
// - sleep after bus low over 2.2 s when permitted
// - sleep on permitted, enabled, held undervoltage
// - wake on bus rise when voltage good
// - both enables zero means no sleep
// - power-up starts in active mode
// - conversions run only while active
// - positive sense difference means charging
// - samples are signed 12-bit two's complement
// - result every 88 ms, 128-sample average
// - out-of-range result clamps to limit
// - internal mode step is 0.625 mA
// - internal mode corrects spread and tempco
// - external mode reports raw sense voltage
// - external mode applies no correction
// - internal range 2.56 A, at least 1.9 A
// - subtract offset bias from every sample
module gpm_top #(
    parameter int unsigned SLEEP_CYC = int'(gpm_pkg::BUS_LOW_SLEEP_CYC),
    parameter int unsigned UV_CYC    = int'(gpm_pkg::UNDERVOLTAGE_CYC),
    parameter int unsigned SMP_CYC   = int'(gpm_pkg::SAMPLE_PERIOD_CYC)
) (
    input  wire logic                                mclk_in,
    input  wire logic                                reset_n_in,
    input  wire logic                                bus_data_in,
    input  wire logic                                sleep_permit_in,
    input  wire logic                    undervoltage_sleep_enable_in,
    input  wire logic                                cell_uv_in,
    input  wire logic                                internal_config_in,
    input  wire logic                                sample_valid_in,
    input  wire logic signed [gpm_pkg::SAMPLE_W-1:0] sense_differential_in,
    input  wire logic signed [gpm_pkg::BIAS_W-1:0]   offset_bias_in,
    input  wire gpm_pkg::gpm_comp_s                  comp_in,
    output logic                                     conv_enable_out,
    output logic                                     sample_req_out,
    output logic                                     sleep_out,
    output logic signed [gpm_pkg::SAMPLE_W-1:0]      current_result_out,
    output logic                                     result_update_out,
    output logic                                     current_charging_out,
    output logic                                     current_discharging_out
);
    import gpm_pkg::*;

    // counters must hold their terminal counts
    if (SLEEP_CYC < 1 || SLEEP_CYC >= (1 << SLEEP_CNT_W) || UV_CYC < 1
        || UV_CYC >= (1 << UV_CNT_W) || SMP_CYC < 2
        || SMP_CYC >= (1 << SMP_CNT_W)) begin : g_bad_cyc
        $error("gpm_top: cycle counts out of counter range");
    end

    // correction gain from die temperature and process trim
    function automatic logic signed [GAIN_W-1:0] gpm_gain(
        input logic signed [TEMP_W-1:0] temp,
        input logic signed [TRIM_W-1:0] trim);
        logic signed [GAIN_W-1:0] dt;
        logic signed [GAIN_W-1:0] tr;
        dt = GAIN_W'(temp) - GAIN_W'(REF_TEMP_CODE);
        tr = GAIN_W'(trim) <<< TRIM_SHIFT;
        return GAIN_W'(GAIN_ONE) + tr - GAIN_W'(ALPHA_Q) * dt;
    endfunction

    // clamp a wide signed value into the result range
    function automatic logic signed [SAMPLE_W-1:0] gpm_sat(
        input logic signed [PROD_W-1:0] v);
        if (v > PROD_W'(RES_MAX)) begin
            return RES_MAX;
        end else if (v < PROD_W'(RES_MIN)) begin
            return RES_MIN;
        end else begin
            return SAMPLE_W'(v);
        end
    endfunction

    gpm_state_s s;
    gpm_state_s next_s;
    logic signed [DIFF_W-1:0] unbiased;
    logic signed [DIFF_W-1:0] avg;
    logic                     avg_done;
    logic                     avg_take;
    logic signed [GAIN_W-1:0] gain;
    logic signed [PROD_W-1:0] comp_val;
    logic                     bus_expired;
    logic                     uv_expired;
    logic                     go_sleep;
    logic                     wake;

    // offset bias removed from each signed sample
    assign unbiased = DIFF_W'(sense_differential_in)
                      - DIFF_W'(offset_bias_in);
    assign avg_take = sample_valid_in && (s.mode == GPM_ACTIVE);

    gpm_avg #(
        .N_SAMPLES (AVG_N)
    ) i_gpm_avg (
        .mclk_in    (mclk_in),
        .reset_n_in (reset_n_in),
        .clear_in   (s.mode == GPM_SLEEP),
        .valid_in   (avg_take),
        .sample_in  (unbiased),
        .avg_out    (avg),
        .done_out   (avg_done)
    );

    // internal mode scales by gain, external passes raw
    assign gain = gpm_gain(comp_in.die_temp, comp_in.gain_trim);
    always_comb begin
        if (internal_config_in) begin
            comp_val = (PROD_W'(avg) * PROD_W'(gain)) >>> GAIN_FRAC;
        end else begin
            comp_val = PROD_W'(avg);
        end
    end

    // sleep and wake conditions
    assign bus_expired = (s.bus_low_cnt == SLEEP_CNT_W'(SLEEP_CYC));
    assign uv_expired  = (s.uv_cnt == UV_CNT_W'(UV_CYC));
    assign go_sleep    = sleep_permit_in && (bus_expired
                         || (undervoltage_sleep_enable_in
                             && uv_expired));
    assign wake = bus_data_in && !s.bus_prev && !s.uv_sync;

    // next-state logic of mode, timers and result
    always_comb begin
        next_s          = s;
        next_s.uv_meta  = cell_uv_in;
        next_s.uv_sync  = s.uv_meta;
        next_s.bus_prev = bus_data_in;
        next_s.smp_req  = 1'b0;
        next_s.update   = 1'b0;
        case (s.mode)
            GPM_ACTIVE: begin
                if (bus_data_in) begin
                    next_s.bus_low_cnt = '0;
                end else if (!bus_expired) begin
                    next_s.bus_low_cnt = s.bus_low_cnt + SLEEP_CNT_W'(1);
                end
                if (!s.uv_sync) begin
                    next_s.uv_cnt = '0;
                end else if (!uv_expired) begin
                    next_s.uv_cnt = s.uv_cnt + UV_CNT_W'(1);
                end
                if (s.smp_cnt == SMP_CNT_W'(SMP_CYC - 1)) begin
                    next_s.smp_cnt = '0;
                    next_s.smp_req = 1'b1;
                end else begin
                    next_s.smp_cnt = s.smp_cnt + SMP_CNT_W'(1);
                end
                if (avg_done && !go_sleep) begin // block dropped on sleep
                    next_s.result      = gpm_sat(comp_val);
                    next_s.update      = 1'b1;
                    next_s.charging    = comp_val > 0;
                    next_s.discharging = comp_val < 0;
                end
                if (go_sleep) begin
                    next_s.mode        = GPM_SLEEP;
                    next_s.bus_low_cnt = '0;
                    next_s.uv_cnt      = '0;
                    next_s.smp_cnt     = '0;
                    next_s.smp_req     = 1'b0;
                end
            end
            GPM_SLEEP: begin
                if (wake) begin
                    next_s.mode = GPM_ACTIVE;
                end
            end
            default: begin
                next_s.mode = GPM_ACTIVE;
            end
        endcase
    end

    // state register, active mode from reset
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s      <= '0;
            s.mode <= GPM_ACTIVE;
        end else begin
            s <= next_s;
        end
    end

    assign conv_enable_out         = (s.mode == GPM_ACTIVE);
    assign sample_req_out          = s.smp_req;
    assign sleep_out               = (s.mode == GPM_SLEEP);
    assign current_result_out      = s.result;
    assign result_update_out       = s.update;
    assign current_charging_out    = s.charging;
    assign current_discharging_out = s.discharging;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);

    property p_bus_sleep;
        s.mode == GPM_ACTIVE && sleep_permit_in && bus_expired
        |=> s.mode == GPM_SLEEP;
    endproperty
    a_bus_sleep: assert property (p_bus_sleep)
        else $error("no sleep after bus low time");

    property p_uv_sleep;
        s.mode == GPM_ACTIVE && sleep_permit_in
        && undervoltage_sleep_enable_in && uv_expired
        |=> s.mode == GPM_SLEEP;
    endproperty
    a_uv_sleep: assert property (p_uv_sleep)
        else $error("no sleep after undervoltage delay");

    property p_wake;
        s.mode == GPM_SLEEP && bus_data_in && !s.bus_prev && !s.uv_sync
        |=> s.mode == GPM_ACTIVE;
    endproperty
    a_wake: assert property (p_wake)
        else $error("no wake on bus rise");

    property p_no_wake_uv;
        s.mode == GPM_SLEEP && s.uv_sync |=> s.mode == GPM_SLEEP;
    endproperty
    a_no_wake_uv: assert property (p_no_wake_uv)
        else $error("woke while undervoltage");

    property p_sleep_needs_permit;
        $rose(sleep_out) |-> $past(sleep_permit_in);
    endproperty
    a_sleep_needs_permit: assert property (p_sleep_needs_permit)
        else $error("sleep entered without permit");

    property p_quiet_sleep;
        sleep_out |-> !conv_enable_out && !sample_req_out
                      && !result_update_out;
    endproperty
    a_quiet_sleep: assert property (p_quiet_sleep)
        else $error("activity during sleep");

    property p_bus_restart;
        s.mode == GPM_ACTIVE && bus_data_in && !go_sleep
        |=> s.bus_low_cnt == '0 && s.mode == GPM_ACTIVE;
    endproperty
    a_bus_restart: assert property (p_bus_restart)
        else $error("bus low timer not restarted");

    property p_uv_gap;
        !cell_uv_in |-> ##3 s.uv_cnt == '0;
    endproperty
    a_uv_gap: assert property (p_uv_gap)
        else $error("undervoltage gap did not restart timer");

    property p_result;
        s.mode == GPM_ACTIVE && avg_done && !go_sleep
        |=> result_update_out
            && current_result_out == gpm_sat($past(comp_val));
    endproperty
    a_result: assert property (p_result)
        else $error("result not stored from average");

    property p_result_hold;
        !result_update_out |-> $stable(current_result_out);
    endproperty
    a_result_hold: assert property (p_result_hold)
        else $error("result changed without update");

    c_bus_sleep: cover property (sleep_permit_in && bus_expired ##1 sleep_out);
    c_uv_sleep:  cover property (uv_expired && !bus_expired ##1 sleep_out);
    c_wake:      cover property (sleep_out ##1 !sleep_out);
    c_update:    cover property (result_update_out && current_charging_out);
endmodule

// ### gpm_host_model.sv
// far-side host model driving the serial bus data line
`timescale 1ns/1ps
module gpm_host_model (
    input  wire logic attached_in,
    input  wire logic pull_low_in,
    output logic      bus_data_out
);
    // host pull-up when attached; device pull-down holds it low otherwise
    // waking is the host releasing the line from low to high
    assign bus_data_out = attached_in & ~pull_low_in;
endmodule

// ### test_gauge_power_mode_current_meas.sv
// self-checking bench for the power-mode and current-average block
`timescale 1ns/1ps
`define CHK(got, exp) check_val(32'(got), 32'(exp))
module test_gauge_power_mode_current_meas;
    import gpm_pkg::*;
    localparam int SLP = 50;
    localparam int UVC = 20;
    logic                       mclk_in    = 1'b0;
    logic                       reset_n_in = 1'b0;
    logic                       attached   = 1'b1;
    logic                       pull_low   = 1'b0;
    logic                       bus_data;
    logic                       permit     = 1'b0;
    logic                       uv_en      = 1'b0;
    logic                       cell_uv    = 1'b0;
    logic                       int_cfg    = 1'b0;
    logic                       valid      = 1'b0;
    logic signed [SAMPLE_W-1:0] sense      = '0;
    logic signed [BIAS_W-1:0]   bias       = '0;
    gpm_comp_s                  comp       = '0;
    logic                       conv, req, sleep, upd, chg, dchg;
    logic signed [SAMPLE_W-1:0] result;
    int                         n_mismatch      = 0;
    int                         samples_checked = 0;

    always #2 mclk_in = ~mclk_in;

    gpm_host_model i_gpm_host_model (.attached_in(attached),
        .pull_low_in(pull_low), .bus_data_out(bus_data));

    gpm_top #(.SLEEP_CYC(SLP), .UV_CYC(UVC), .SMP_CYC(10)) i_gpm_top (
        .mclk_in(mclk_in), .reset_n_in(reset_n_in), .bus_data_in(bus_data),
        .sleep_permit_in(permit), .undervoltage_sleep_enable_in(uv_en),
        .cell_uv_in(cell_uv), .internal_config_in(int_cfg),
        .sample_valid_in(valid), .sense_differential_in(sense),
        .offset_bias_in(bias), .comp_in(comp), .conv_enable_out(conv),
        .sample_req_out(req), .sleep_out(sleep),
        .current_result_out(result), .result_update_out(upd),
        .current_charging_out(chg), .current_discharging_out(dchg));

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error t=%0t got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk_in);
    endtask

    // bounded wait on the sleep flag or the update pulse
    task automatic wait_flag(input bit on_upd, input logic lvl, input int b);
        for (int i = 0; i < b; i++) begin
            if ((on_upd ? upd : sleep) === lvl) return;
            cyc(1);
        end
        n_mismatch++;
        $display("Error t=%0t wait ran out", $time);
        test_done();
    endtask

    // low pulse then release: the wake edge
    task automatic wake_pulse();
        pull_low = 1'b1;
        cyc(2);
        pull_low = 1'b0;
    endtask

    task automatic send_block(input int n, input int v);
        sense = v[SAMPLE_W-1:0];
        valid = 1'b1;
        cyc(n);
        valid = 1'b0;
    endtask

    task automatic t_reset();
        cyc(9);
        `CHK(sleep, 0);
        `CHK(conv, 1);
        `CHK(result, 0);
        cyc(1);
        reset_n_in = 1'b1;
    endtask

    task automatic t_no_permit();
        cell_uv = 1'b1;
        cyc(80);
        `CHK(sleep, 0);
        attached = 1'b1;
        cell_uv = 1'b0;
        cyc(4);
    endtask

    task automatic t_bus_sleep();
        int n;
        n = 0;
        for (int i = 0; i < 30; i++) begin
            n += int'(req);
            cyc(1);
        end
        `CHK(n, 3);
        permit = 1'b1;
        attached = 1'b0;
        cyc(30);
        attached = 1'b1;
        cyc(1);
        attached = 1'b0;
        cyc(SLP);
        `CHK(sleep, 0);
        wait_flag(0, 1'b1, 4);
        `CHK(conv, 0);
    endtask

    task automatic t_wake();
        cell_uv = 1'b1;
        cyc(4);
        attached = 1'b1;
        cyc(6);
        `CHK(sleep, 1);
        cell_uv = 1'b0;
        cyc(4);
        wake_pulse();
        wait_flag(0, 1'b0, 3);
        `CHK(conv, 1);
    endtask

    task automatic t_uv_sleep();
        uv_en = 1'b1;
        cell_uv = 1'b1;
        cyc(15);
        cell_uv = 1'b0;
        cyc(4);
        cell_uv = 1'b1;
        cyc(UVC);
        `CHK(sleep, 0);
        wait_flag(0, 1'b1, 8);
        cell_uv = 1'b0;
        uv_en = 1'b0;
        cyc(4);
        wake_pulse();
        wait_flag(0, 1'b0, 3);
    endtask

    // one full block, expectation from config, bias and compensation
    task automatic avg_case(input bit ic, input int v, input int b,
                            input int tmp, input int trm);
        longint g, pre, exp;
        int_cfg = ic;
        bias = b[BIAS_W-1:0]; // offset left by host calibration
        comp.die_temp = tmp[TEMP_W-1:0];
        comp.gain_trim = trm[TRIM_W-1:0];
        g = 32768 + trm * 16 - 15 * (tmp - 200);
        pre = ic ? ((longint'(v - b) * g) >>> 15) : longint'(v - b);
        exp = pre > 2047 ? 2047 : (pre < -2048 ? -2048 : pre);
        send_block(128, v);
        wait_flag(1, 1'b1, 4);
        `CHK(result, exp);
        `CHK(chg, pre > 0);
        `CHK(dchg, pre < 0);
        cyc(1);
    endtask

    task automatic t_discard();
        int_cfg = 1'b0;
        bias = '0;
        send_block(64, 500);
        attached = 1'b0;
        cyc(SLP);
        wait_flag(0, 1'b1, 4);
        valid = 1'b1;
        sense = 12'sh2bc;
        for (int i = 0; i < 20; i++) begin
            `CHK(req, 0);
            `CHK(upd, 0);
            cyc(1);
        end
        valid = 1'b0;
        attached = 1'b1;
        wait_flag(0, 1'b0, 3);
        avg_case(0, -7, 0, 200, 0);
    endtask

    initial begin
        attached = 1'b0;
        t_reset();
        t_no_permit();
        t_bus_sleep();
        t_wake();
        t_uv_sleep();
        avg_case(0, 100, 5, 200, 0);
        avg_case(0, -300, -20, 200, 0);
        avg_case(0, 2047, -128, 200, 0);
        avg_case(0, -2048, 127, 200, 0);
        avg_case(1, 1000, 0, 200, 0);
        avg_case(1, 1000, 0, 208, 16);
        avg_case(0, 1000, 0, 208, 16);
        avg_case(1, 2000, 0, 200, 127);
        t_discard();
        test_done();
    end

    // overall guard against a hang
    initial begin
        #200000;
        n_mismatch++;
        $display("Error t=%0t run limit reached", $time);
        test_done();
    end
endmodule
